// *** src/local_register_frame_cache.sv ***
// Local register frame cache: eight on-chip frames, spills oldest to memory
// Overview of operation
// - Hold up to eight frames on chip
// - Frame holds all sixteen local registers
// - Frames move over 128-bit path
// - A call in idle, with no flush or branch-and-link, pushes the active set; a call while busy is dropped
// - Eighth frame held spills the oldest
// - Branch-and-link never pushes a frame
// - Flush-all copies every frame out
// - High priority: interrupted and priority at least 28
// - Reserved count from config bits 10:8
// - Non-critical push below reserve spills oldest
// - Reserve checked only on push
// - Limit seven minus reserve; over limit spills
// - High-priority push uses reserved frame; spills only when eighth frame held
// - Reserved count lies in 0 to 7
// - Reserve one leaves six shared frames
// - Reserve seven: every non-critical push spills
// - Oversized reserve: low priority always spills
// - Priority is five bits, 16 to 20
// - State flag one means interrupted
`timescale 1ns/1ns
module local_register_frame_cache (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          call_push_i,
  input  wire logic          bal_i,
  input  wire logic          flush_all_i,
  input  wire logic [511:0]  local_set_i,
  input  wire logic [31:0]   reserve_config_word_i,
  input  wire logic [31:0]   process_controls_i,
  output logic               busy_o,
  output logic               done_o,
  output logic [3:0]         frame_count_o,
  output logic               spill_valid_o,
  input  wire logic          spill_ready_i,
  output logic [127:0]       spill_data_o
);
  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  function automatic logic high_prio(input logic [31:0] pc);
    high_prio = pc[frame_cache_pkg::STATE_BIT] &&
                (pc[frame_cache_pkg::PRIO_MSB:frame_cache_pkg::PRIO_LSB]
                 >= frame_cache_pkg::HIGH_PRIO_MIN);
  endfunction : high_prio

  function automatic logic last_beat(input logic [1:0] beat);
    last_beat = (beat == 2'h3);
  endfunction : last_beat

  logic [2:0] resv;
  logic [3:0] limit_p1;
  assign resv     = reserve_config_word_i[frame_cache_pkg::RESV_MSB:frame_cache_pkg::RESV_LSB];
  // Limit plus one is 8 minus reserve; reserve 7 gives 1 so any non-critical push spills
  assign limit_p1 = frame_cache_pkg::NONCRIT_BASE - {1'b0, resv} + 4'h1;

  // ------------------------------------------------------------
  // Frame storage: 8 slots x 4 beats of 128 bits
  // ------------------------------------------------------------
  logic [127:0] store [frame_cache_pkg::FRAME_SLOTS][frame_cache_pkg::BEATS];
  logic [511:0] pend_r, pend_nxt;
  logic [2:0]   head_r, head_nxt;
  logic [2:0]   tail_r, tail_nxt;
  logic [3:0]   count_r, count_nxt;
  logic [1:0]   beat_r, beat_nxt;
  logic         crit_r, crit_nxt;
  logic         done_r, done_nxt;
  frame_cache_pkg::fc_state_e state_r, state_nxt;

  spill_stream_if #(.W(128)) sp ();

  logic wr_store;
  logic spill_need;
  assign wr_store   = (state_r == frame_cache_pkg::ST_PUSH);
  // Check after the push: count_r already includes the new frame
  assign spill_need = (count_r == frame_cache_pkg::FULL_COUNT) ||
                      (!crit_r && (count_r >= limit_p1));

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    pend_nxt  = pend_r;
    head_nxt  = head_r;
    tail_nxt  = tail_r;
    count_nxt = count_r;
    beat_nxt  = beat_r;
    crit_nxt  = crit_r;
    done_nxt  = 1'b0;
    sp.valid  = 1'b0;
    sp.data   = store[tail_r][beat_r];
    unique case (state_r)
      frame_cache_pkg::ST_IDLE: begin
        if (flush_all_i) begin
          beat_nxt = 2'h0;
          if (count_r == frame_cache_pkg::COUNT_RST) begin
            done_nxt = 1'b1;
          end else begin
            state_nxt = frame_cache_pkg::ST_FLUSH;
          end
        end else if (call_push_i && !bal_i) begin
          pend_nxt  = local_set_i;
          crit_nxt  = high_prio(process_controls_i);
          beat_nxt  = 2'h0;
          state_nxt = frame_cache_pkg::ST_PUSH;
        end
      end
      frame_cache_pkg::ST_PUSH: begin
        // Four beats of the 128-bit path fill one slot
        beat_nxt = beat_r + 2'h1;
        if (last_beat(beat_r)) begin
          head_nxt  = head_r + 3'h1;
          count_nxt = count_r + 4'h1;
          state_nxt = frame_cache_pkg::ST_SPILL;
        end
      end
      frame_cache_pkg::ST_SPILL: begin
        if (!spill_need) begin
          done_nxt  = 1'b1;
          state_nxt = frame_cache_pkg::ST_IDLE;
        end else begin
          sp.valid = 1'b1;
          if (sp.ready) begin
            beat_nxt = beat_r + 2'h1;
            if (last_beat(beat_r)) begin
              tail_nxt  = tail_r + 3'h1;
              count_nxt = count_r - 4'h1;
              done_nxt  = 1'b1;
              state_nxt = frame_cache_pkg::ST_IDLE;
            end
          end
        end
      end
      frame_cache_pkg::ST_FLUSH: begin
        sp.valid = 1'b1;
        if (sp.ready) begin
          beat_nxt = beat_r + 2'h1;
          if (last_beat(beat_r)) begin
            tail_nxt  = tail_r + 3'h1;
            count_nxt = count_r - 4'h1;
            if (count_r == 4'h1) begin
              done_nxt  = 1'b1;
              state_nxt = frame_cache_pkg::ST_IDLE;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (wr_store) begin
      store[head_r][beat_r] <= pend_r[beat_r*128 +: 128];
    end
    if (!rst_n_i) begin
      state_r <= frame_cache_pkg::ST_IDLE;
      pend_r  <= '0;
      head_r  <= 3'h0;
      tail_r  <= 3'h0;
      count_r <= frame_cache_pkg::COUNT_RST;
      beat_r  <= 2'h0;
      crit_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r  <= pend_nxt;
      head_r  <= head_nxt;
      tail_r  <= tail_nxt;
      count_r <= count_nxt;
      beat_r  <= beat_nxt;
      crit_r  <= crit_nxt;
      done_r  <= done_nxt;
    end
  end

  // ------------------------------------------------------------
  // Spill buffer; stalls the sequencer when memory is slow
  // ------------------------------------------------------------
  spill_fifo #(
    .W     (128),
    .DEPTH (frame_cache_pkg::SPILL_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .wr         (sp),
    .rd_valid_o (spill_valid_o),
    .rd_ready_i (spill_ready_i),
    .rd_data_o  (spill_data_o)
  );

  assign busy_o        = (state_r != frame_cache_pkg::ST_IDLE);
  assign done_o        = done_r;
  assign frame_count_o = count_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_count_max;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      count_r <= frame_cache_pkg::FULL_COUNT;
  endproperty
  a_count_max: assert property (p_count_max) else $error("frame count above eight");

  property p_idle_below_full;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_IDLE) |-> (count_r < frame_cache_pkg::FULL_COUNT);
  endproperty
  a_idle_below_full: assert property (p_idle_below_full) else $error("cache left full");

  property p_bal_no_push;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_IDLE && bal_i && !flush_all_i) |=> (state_r == frame_cache_pkg::ST_IDLE);
  endproperty
  a_bal_no_push: assert property (p_bal_no_push) else $error("branch-and-link pushed");

  property p_push_beats;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(state_r == frame_cache_pkg::ST_PUSH) |-> (state_r == frame_cache_pkg::ST_PUSH) [*4]
        ##1 (state_r == frame_cache_pkg::ST_SPILL);
  endproperty
  a_push_beats: assert property (p_push_beats) else $error("push not four beats");

  property p_flush_empties;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_FLUSH && state_nxt == frame_cache_pkg::ST_IDLE) |=> (count_r == 4'h0);
  endproperty
  a_flush_empties: assert property (p_flush_empties) else $error("flush left frames");

  property p_crit_no_spill;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_SPILL && crit_r && count_r < frame_cache_pkg::FULL_COUNT)
        |-> !sp.valid;
  endproperty
  a_crit_no_spill: assert property (p_crit_no_spill) else $error("critical push spilled");

  property p_noncrit_limit;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_SPILL && !crit_r && count_r >= limit_p1) |-> sp.valid;
  endproperty
  a_noncrit_limit: assert property (p_noncrit_limit) else $error("reserve not enforced");

  property p_spill_decrements;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_SPILL && sp.valid && sp.ready && beat_r == 2'h3)
        |=> (count_r == $past(count_r) - 4'h1) && done_o;
  endproperty
  a_spill_decrements: assert property (p_spill_decrements) else $error("spill count wrong");

  property p_reset_empty;
    @(posedge sys_clk_i) !rst_n_i |=> (count_r == 4'h0) && !busy_o;
  endproperty
  a_reset_empty: assert property (p_reset_empty) else $error("reset not empty");

  // ------------------------------------------------------------
  // Push and spill checks
  // ------------------------------------------------------------
  property p_push_taken;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_IDLE && call_push_i && !bal_i && !flush_all_i)
        |=> (state_r == frame_cache_pkg::ST_PUSH);
  endproperty
  a_push_taken: assert property (p_push_taken) else $error("call did not push");

  property p_flush_taken;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_IDLE && flush_all_i && count_r != frame_cache_pkg::COUNT_RST)
        |=> (state_r == frame_cache_pkg::ST_FLUSH);
  endproperty
  a_flush_taken: assert property (p_flush_taken) else $error("flush not started");

  property p_push_count;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_PUSH && last_beat(beat_r))
        |=> (count_r == $past(count_r) + 4'h1);
  endproperty
  a_push_count: assert property (p_push_count) else $error("push did not add a frame");

  property p_crit_held;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r != frame_cache_pkg::ST_IDLE && $past(state_r) != frame_cache_pkg::ST_IDLE)
        |-> $stable(crit_r);
  endproperty
  a_crit_held: assert property (p_crit_held) else $error("priority test changed after push");

  property p_ring_count;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (head_r - tail_r) == count_r[2:0];
  endproperty
  a_ring_count: assert property (p_ring_count) else $error("slot pointers disagree with count");

  property p_tail_moves;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      $changed(tail_r) |-> (count_r == $past(count_r) - 4'h1);
  endproperty
  a_tail_moves: assert property (p_tail_moves) else $error("slot left out of order");

  property p_resv7_spills;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_SPILL && !crit_r && resv == 3'h7) |-> sp.valid;
  endproperty
  a_resv7_spills: assert property (p_resv7_spills) else $error("non-critical frame kept");

  property p_resv0_full_only;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_SPILL && resv == 3'h0 && count_r != frame_cache_pkg::FULL_COUNT)
        |-> !sp.valid;
  endproperty
  a_resv0_full_only: assert property (p_resv0_full_only) else $error("spill below full");

  property p_beat_order;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (sp.valid && sp.ready && !last_beat(beat_r)) |=> (beat_r == $past(beat_r) + 2'h1);
  endproperty
  a_beat_order: assert property (p_beat_order) else $error("spill beats out of order");

  property p_done_idle;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      done_o |-> (state_r == frame_cache_pkg::ST_IDLE);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while busy");

  property p_flush_nonempty;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_FLUSH) |-> (count_r != frame_cache_pkg::COUNT_RST);
  endproperty
  a_flush_nonempty: assert property (p_flush_nonempty) else $error("flush ran past empty");

  property p_full_spills;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_SPILL && count_r == frame_cache_pkg::FULL_COUNT) |-> sp.valid;
  endproperty
  a_full_spills: assert property (p_full_spills) else $error("eighth frame kept");

  property p_resv1_shared;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_SPILL && !crit_r && resv == 3'h1 && count_r == 4'h7)
        |-> sp.valid;
  endproperty
  a_resv1_shared: assert property (p_resv1_shared) else $error("seventh shared frame kept");

  property p_idle_no_spill;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (state_r == frame_cache_pkg::ST_IDLE) |-> !sp.valid;
  endproperty
  a_idle_no_spill: assert property (p_idle_no_spill) else $error("spill outside a push");
endmodule : local_register_frame_cache

// *** include/frame_cache_pkg.sv ***
// Constants and types shared by the local register frame cache
package frame_cache_pkg;
  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int unsigned FRAME_SLOTS    = 8;
  localparam int unsigned REGS_PER_FRAME = 16;
  localparam int unsigned REG_W          = 32;
  localparam int unsigned PATH_W         = 128;
  localparam int unsigned BEATS          = REGS_PER_FRAME * REG_W / PATH_W;
  localparam int unsigned SLOT_W         = 3;
  localparam int unsigned COUNT_W        = 4;
  localparam int unsigned BEAT_W         = 2;
  localparam int unsigned SPILL_FIFO_DEPTH = 16;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned RESV_LSB       = 8;
  localparam int unsigned RESV_MSB       = 10;
  localparam int unsigned PRIO_LSB       = 16;
  localparam int unsigned PRIO_MSB       = 20;
  localparam int unsigned STATE_BIT      = 13;
  // ------------------------------------------------------------
  // Values
  // ------------------------------------------------------------
  localparam logic [4:0]  HIGH_PRIO_MIN  = 5'h1C;
  localparam logic [3:0]  NONCRIT_BASE   = 4'h7;
  localparam logic [3:0]  FULL_COUNT     = 4'h8;
  localparam logic [3:0]  COUNT_RST      = 4'h0;
  localparam logic [2:0]  RESV_RST       = 3'h0;
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_SPILL, ST_FLUSH} fc_state_e;
endpackage : frame_cache_pkg

// *** include/spill_stream_if.sv ***
// Valid/ready word stream between the frame cache and its spill FIFO
`timescale 1ns/1ns
interface spill_stream_if #(parameter int unsigned W = 128) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : spill_stream_if

// *** src/spill_fifo.sv ***
// Spill path FIFO with registered read data
`timescale 1ns/1ns
module spill_fifo #(
  parameter int unsigned W     = 128,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  spill_stream_if.snk       wr,
  output logic              rd_valid_o,
  input  wire logic         rd_ready_i,
  output logic [W-1:0]      rd_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wp_r, wp_nxt, rp_r, rp_nxt;
  logic          ov_r, ov_nxt;
  logic [W-1:0]  od_r, od_nxt;
  logic          full, empty, do_wr, do_rd;
  // Output register counts as one extra slot
  assign full       = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty      = (wp_r == rp_r);
  assign wr.ready   = !full;
  assign do_wr      = wr.valid && !full;
  assign do_rd      = !empty && (!ov_r || rd_ready_i);
  assign rd_valid_o = ov_r;
  assign rd_data_o  = od_r;
  always_comb begin
    wp_nxt = do_wr ? wp_r + {{AW{1'b0}}, 1'b1} : wp_r;
    rp_nxt = do_rd ? rp_r + {{AW{1'b0}}, 1'b1} : rp_r;
    ov_nxt = do_rd ? 1'b1 : (rd_ready_i ? 1'b0 : ov_r);
    od_nxt = do_rd ? mem[rp_r[AW-1:0]] : od_r;
  end
  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem[wp_r[AW-1:0]] <= wr.data;
    end
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      ov_r <= 1'b0;
      od_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      ov_r <= ov_nxt;
      od_r <= od_nxt;
    end
  end
endmodule : spill_fifo

// *** verif/mem_stack_model.sv ***
// Behavioural external procedure stack that takes spilled words
`timescale 1ns/1ns
module mem_stack_model (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         stall_i,
  input  wire logic         valid_i,
  input  wire logic [127:0] data_i,
  output logic              ready_o
);
  // ------------------------------------------------------------
  // Word store
  // ------------------------------------------------------------
  logic [127:0] words_q[$];

  // Registered ready: a stall shows one cycle late, as on a real bus
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !stall_i;
      if (valid_i && ready_o) begin
        words_q.push_back(data_i);
      end
    end
  end
endmodule : mem_stack_model

// *** verif/test_local_register_frame_cache.sv ***
// Self-checking bench for the local register frame cache
`timescale 1ns/1ns
module test_local_register_frame_cache;
  // ------------------------------------------------------------
  // Signals and table
  // ------------------------------------------------------------
  typedef struct {logic [1:0] op; int rep; logic [2:0] resv; logic [31:0] pcw; logic [3:0] cnt;} row_s;
  localparam logic [31:0] NC   = 32'h0000_0000;
  localparam logic [31:0] CRIT = 32'h003c_2000;
  localparam logic [31:0] P27  = 32'h001b_2000;
  localparam logic [31:0] EXEC = 32'h001f_0000;
  logic         sys_clk_i, rst_n_i, call_push_i, bal_i, flush_all_i, stall;
  logic         busy_o, done_o, spill_valid_o, spill_ready;
  logic [511:0] local_set_i;
  logic [31:0]  reserve_config_word_i, process_controls_i;
  logic [3:0]   frame_count_o;
  logic [127:0] spill_data_o;
  logic [511:0] fr_q[$];
  logic [127:0] exp_q[$];
  int           error_cnt, checked, seq, prev;
  // Ops: 0 push, 1 branch-and-link, 2 idle, 3 flush
  row_s rows [15] = '{
    '{2'h0, 7, 3'h0, NC, 4'h7},
    '{2'h0, 1, 3'h0, NC, 4'h7},
    '{2'h1, 1, 3'h0, NC, 4'h7},
    '{2'h3, 1, 3'h0, NC, 4'h0},
    '{2'h0, 1, 3'h7, NC, 4'h0},
    '{2'h0, 1, 3'h7, P27, 4'h0},
    '{2'h0, 1, 3'h7, EXEC, 4'h0},
    '{2'h0, 1, 3'h7, CRIT, 4'h1},
    '{2'h0, 1, 3'h7, NC, 4'h1},
    '{2'h3, 1, 3'h7, NC, 4'h0},
    '{2'h0, 6, 3'h1, NC, 4'h6},
    '{2'h0, 1, 3'h1, NC, 4'h6},
    '{2'h0, 1, 3'h1, CRIT, 4'h7},
    '{2'h2, 1, 3'h1, NC, 4'h7},
    '{2'h0, 1, 3'h1, CRIT, 4'h7}
  };

  local_register_frame_cache dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .call_push_i(call_push_i), .bal_i(bal_i),
    .flush_all_i(flush_all_i), .local_set_i(local_set_i), .reserve_config_word_i(reserve_config_word_i),
    .process_controls_i(process_controls_i), .busy_o(busy_o), .done_o(done_o), .frame_count_o(frame_count_o),
    .spill_valid_o(spill_valid_o), .spill_ready_i(spill_ready), .spill_data_o(spill_data_o));

  mem_stack_model mem_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .valid_i(spill_valid_o),
    .data_i(spill_data_o), .ready_o(spill_ready));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [511:0] mk_set(input int n);
    logic [511:0] s;
    for (int j = 0; j < 16; j++) begin
      s[j*32 +: 32] = {16'(n), 16'(j)};
    end
    return s;
  endfunction : mk_set

  task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Oldest frame leaves first, beat 0 holding r0..
  task automatic spill_one();
    logic [511:0] f;
    f = fr_q.pop_front();
    for (int b = 0; b < 4; b++) begin
      exp_q.push_back(f[b*128 +: 128]);
    end
  endtask : spill_one

  task automatic run_op(input logic [1:0] op, input logic [2:0] resv, input logic [31:0] pcw);
    @(negedge sys_clk_i);
    // Bit 11 and low bits set so only bits 10:8 may count
    reserve_config_word_i = 32'h0000_08ff | (32'(resv) << 8);
    process_controls_i = pcw;
    local_set_i = mk_set(seq);
    call_push_i = (op <= 2'h1);
    bal_i = (op == 2'h1);
    flush_all_i = (op == 2'h3);
    if (op == 2'h0) begin
      fr_q.push_back(local_set_i);
    end
    while (op == 2'h3 && fr_q.size() > 0) begin
      spill_one();
    end
    seq++;
    @(negedge sys_clk_i);
    call_push_i = 1'b0;
    bal_i = 1'b0;
    flush_all_i = 1'b0;
  endtask : run_op

  task automatic finish_op(input logic [3:0] cnt, input logic has_done);
    if (has_done) begin
      for (int i = 0; i < 3000 && done_o !== 1'b1; i++) begin
        @(negedge sys_clk_i);
      end
      check("done", 128'(done_o), 128'h1);
    end else begin
      repeat (10) @(negedge sys_clk_i);
    end
    @(negedge sys_clk_i);
    check("count", 128'(frame_count_o), 128'(cnt));
    check("busy", 128'(busy_o), 128'h0);
  endtask : finish_op

  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Clock, watchdog, sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Whole run is about five hundred cycles; this allows sixty times that
  initial begin
    #300_000;
    error_cnt++;
    test_done();
  end

  initial begin
    {rst_n_i, call_push_i, bal_i, flush_all_i, stall} = 5'h00;
    local_set_i = '0;
    reserve_config_word_i = 32'h0000_0000;
    process_controls_i = 32'h0000_0000;
    repeat (6) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check("reset count", 128'(frame_count_o), 128'h0);
    check("reset flags", 128'({busy_o, done_o, spill_valid_o}), 128'h0);
    rst_n_i = 1'b1;
    prev = 0;
    foreach (rows[r]) begin
      for (int k = 0; k < rows[r].rep; k++) begin
        run_op(rows[r].op, rows[r].resv, rows[r].pcw);
        finish_op((k < rows[r].rep - 1) ? 4'(prev + k + 1) : rows[r].cnt, rows[r].op inside {2'h0, 2'h3});
      end
      if (rows[r].op == 2'h0) begin
        repeat (prev + rows[r].rep - int'(rows[r].cnt)) spill_one();
      end
      prev = rows[r].cnt;
    end
    // Memory stalls during a full flush: FIFO fills and refuses
    stall = 1'b1;
    run_op(2'h3, 3'h1, NC);
    repeat (120) @(negedge sys_clk_i);
    check("stalled busy", 128'({busy_o, spill_valid_o}), 128'h3);
    stall = 1'b0;
    finish_op(4'h0, 1'b1);
    // Empty flush answers in the next cycle
    run_op(2'h3, 3'h1, NC);
    check("empty flush done", 128'(done_o), 128'h1);
    // A push raised while busy is dropped
    run_op(2'h0, 3'h1, NC);
    repeat (2) @(negedge sys_clk_i);
    call_push_i = 1'b1;
    @(negedge sys_clk_i);
    call_push_i = 1'b0;
    finish_op(4'h1, 1'b1);
    run_op(2'h3, 3'h1, NC);
    finish_op(4'h0, 1'b1);
    // Reset in mid-run drops a held frame without spilling it
    run_op(2'h0, 3'h1, NC);
    finish_op(4'h1, 1'b1);
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    check("mid reset count", 128'(frame_count_o), 128'h0);
    check("mid reset flags", 128'({busy_o, done_o, spill_valid_o}), 128'h0);
    rst_n_i = 1'b1;
    repeat (40) @(negedge sys_clk_i);
    check("spill words", 128'(mem_u.words_q.size()), 128'(exp_q.size()));
    foreach (exp_q[i]) begin
      check("spill word", mem_u.words_q[i], exp_q[i]);
    end
    test_done();
  end
endmodule : test_local_register_frame_cache
